// [msc_ctrl.sv]
// Purpose: Host-side mode-set sequencer for a memory device, APB programmed
// Assumes: Device idle state reported on dev_idle by the wider controller
// Notes: Special-timing updates end at the mode-set-to-mode-set wait only
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "msc_map.svh"
module msc_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state from the wider controller
  input wire logic dev_idle,
  input wire logic cke_high,
  // Command block to the wider controller
  output logic cmd_block,
  // Device command pins
  output msc_pkg::msc_cmd_t dev_cmd,
  output logic termination_input
);
  msc_pkg::msc_state_t state_q, state_d;
  logic [21:0] data_q, data_d;
  logic rtt_q, rtt_d, gear_q, gear_d, spec_q, spec_d;
  logic err_q, err_d, done_q, done_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] gap_q, gap_d;
  msc_pkg::msc_cmd_t cmd_q, cmd_d;
  logic odt_q, odt_d;
  logic wr_en, rd_en, go;

  // Reserved encodings and gear-down conflicts
  function automatic logic bad_code(input logic [21:0] v, input logic gear);
    logic [3:0] wr;
    logic [4:0] cl;
    logic fn;
    wr = {v[13], v[11:9]};
    cl = {v[12], v[6:4], v[2]};
    fn = 1'b0;
    bad_code = 1'b0;
    if (v[20:18] == 3'h7) begin
      bad_code = 1'b1;
    end
    if (v[20:18] == 3'h0) begin
      if (v[`MSC_BIT_RFU_HI] || v[`MSC_BIT_RFU_LO]) begin
        bad_code = 1'b1;
      end
      if (v[`MSC_BIT_TM]) begin
        bad_code = 1'b1;
      end
      if (wr > 4'h9) begin
        bad_code = 1'b1;
      end
      if (v[1:0] == 2'h3) begin
        bad_code = 1'b1;
      end
      if (cl > 5'h17) begin
        bad_code = 1'b1;
      end
      fn = (wr == 4'h0) || (wr == 4'h2) || (wr == 4'h4) ||
        (wr == 4'h7) || (wr == 4'h8) || cl[0] == 1'b0 && cl < 5'h08 ||
        cl[4:2] == 3'b011;
      if (gear && fn) begin
        bad_code = 1'b1;
      end
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign go = wr_en && paddr == `MSC_OFF_CTRL && pwdata[`MSC_CTRL_GO];
  assign dev_cmd = cmd_q;
  assign termination_input = odt_q;
  // Other commands held off while any wait runs
  assign cmd_block = state_q != msc_pkg::MSC_IDLE;

  always_comb begin
    data_d = data_q;
    rtt_d = rtt_q;
    gear_d = gear_q;
    spec_d = spec_q;
    err_d = err_q;
    done_d = done_q;
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
      we_n: 1'b1, bg: 2'h0, ba: 2'h0, addr: 18'h0_0000};
    odt_d = odt_q;
    if (wr_en && paddr == `MSC_OFF_DATA && state_q == msc_pkg::MSC_IDLE) begin
      data_d = pwdata[21:0];
    end
    if (wr_en && paddr == `MSC_OFF_CTRL) begin
      rtt_d = pwdata[`MSC_CTRL_RTT];
      gear_d = pwdata[`MSC_CTRL_GEAR];
      spec_d = pwdata[`MSC_CTRL_SPECIAL];
    end
    if (wr_en && paddr == `MSC_OFF_STAT) begin
      err_d = err_q && !pwdata[`MSC_STAT_ERR];
      done_d = done_q && !pwdata[`MSC_STAT_DONE];
    end
    unique case (state_q)
      msc_pkg::MSC_IDLE: begin
        odt_d = 1'b0;
        if (go && !(dev_idle && cke_high)) begin
          err_d = 1'b1;
        end else if (go && bad_code(data_q, pwdata[`MSC_CTRL_GEAR])) begin
          err_d = 1'b1;
        end else if (go) begin
          state_d = msc_pkg::MSC_ISSUE;
        end
      end
      msc_pkg::MSC_ISSUE: begin
        cmd_d.cs_n = 1'b0;
        cmd_d.ras_n = 1'b0;
        cmd_d.cas_n = 1'b0;
        cmd_d.we_n = 1'b0;
        cmd_d.bg = data_q[21:20];
        cmd_d.ba = data_q[19:`MSC_SEL_LO];
        cmd_d.addr = {data_q[17], 3'h0, data_q[13:0]};
        cnt_d = `MSC_MRD_CYC;
        state_d = msc_pkg::MSC_WAIT_MRD;
      end
      msc_pkg::MSC_WAIT_MRD: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          if (spec_q) begin
            state_d = msc_pkg::MSC_IDLE;
            done_d = 1'b1;
          end else begin
            cnt_d = `MSC_MOD_CYC - `MSC_MRD_CYC;
            state_d = msc_pkg::MSC_WAIT_MOD;
          end
        end
      end
      msc_pkg::MSC_WAIT_MOD: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          state_d = msc_pkg::MSC_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
    // Termination stays low in every state, idle included
    if (state_d == msc_pkg::MSC_IDLE && state_q == msc_pkg::MSC_IDLE &&
        !rtt_q) begin
      odt_d = 1'b0;
    end
    if (state_q != msc_pkg::MSC_IDLE) begin
      odt_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= msc_pkg::MSC_IDLE;
      data_q <= 22'h00_0000;
      rtt_q <= 1'b0;
      gear_q <= 1'b0;
      spec_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 8'h00;
      cmd_q <= '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
        we_n: 1'b1, bg: 2'h0, ba: 2'h0, addr: 18'h0_0000};
      odt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      data_q <= data_d;
      rtt_q <= rtt_d;
      gear_q <= gear_d;
      spec_q <= spec_d;
      err_q <= err_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      odt_q <= odt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        `MSC_OFF_CTRL: prdata <= {28'h000_0000, spec_q, gear_q, rtt_q, 1'b0};
        `MSC_OFF_DATA: prdata <= {10'h000, data_q};
        `MSC_OFF_STAT: prdata <= {28'h000_0000, dev_idle && cke_high, done_q,
          err_q, state_q != msc_pkg::MSC_IDLE};
        `MSC_OFF_TIME: prdata <= {16'h0000, `MSC_MOD_CYC, `MSC_MRD_CYC};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Cycles since the last mode-set, saturating
  always_comb begin
    gap_d = gap_q;
    if (!cmd_q.cs_n) begin
      gap_d = 8'h01;
    end else if (gap_q != 8'hFF) begin
      gap_d = gap_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_q <= 8'hFF;
    end else begin
      gap_q <= gap_d;
    end
  end

  property p_mrs_pins;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> !dev_cmd.ras_n && !dev_cmd.cas_n && !dev_cmd.we_n;
  endproperty
  a_mrs_pins: assert property (p_mrs_pins) else $error("strobes");

  property p_mrd_gap;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |=> dev_cmd.cs_n [*8];
  endproperty
  a_mrd_gap: assert property (p_mrd_gap) else $error("gap short");

  property p_block;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> cmd_block;
  endproperty
  a_block: assert property (p_block) else $error("not blocked");

  property p_odt;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> !termination_input ##1 !termination_input [*8];
  endproperty
  a_odt: assert property (p_odt) else $error("termination high");

  property p_sel;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> {dev_cmd.bg[0], dev_cmd.ba} != 3'h7;
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");

  property p_map;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> dev_cmd.addr[13:0] == data_q[13:0];
  endproperty
  a_map: assert property (p_map) else $error("bad mapping");

  property p_tm;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n && dev_cmd.ba == 2'h0 && dev_cmd.bg == 2'h0 |->
        !dev_cmd.addr[7];
  endproperty
  a_tm: assert property (p_tm) else $error("test mode");

  property p_idle;
    @(posedge clk) disable iff (!resetn)
      state_q == msc_pkg::MSC_IDLE && state_d == msc_pkg::MSC_ISSUE |->
        dev_idle && cke_high;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");

  property p_mod;
    @(posedge clk) disable iff (!resetn)
      $fell(cmd_block) |-> (gap_q == `MSC_MOD_CYC ||
        spec_q && gap_q == `MSC_MRD_CYC);
  endproperty
  a_mod: assert property (p_mod) else $error("wait length");

  property p_refuse;
    @(posedge clk) disable iff (!resetn)
      state_q == msc_pkg::MSC_IDLE && go && !(dev_idle && cke_high) |=>
        state_q == msc_pkg::MSC_IDLE && err_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused go");

  property p_bad;
    @(posedge clk) disable iff (!resetn)
      state_q == msc_pkg::MSC_IDLE && go &&
        bad_code(data_q, pwdata[`MSC_CTRL_GEAR]) |=>
        state_q == msc_pkg::MSC_IDLE && err_q;
  endproperty
  a_bad: assert property (p_bad) else $error("bad code ran");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
      state_q != msc_pkg::MSC_IDLE |=> $stable(data_q);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");

  property p_map_hi;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> {dev_cmd.bg, dev_cmd.ba, dev_cmd.addr[17]} ==
        data_q[21:17];
  endproperty
  a_map_hi: assert property (p_map_hi) else $error("upper map");

  property p_rfu;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n && {dev_cmd.bg[0], dev_cmd.ba} == 3'h0 |->
        !dev_cmd.bg[1] && !dev_cmd.addr[17];
  endproperty
  a_rfu: assert property (p_rfu) else $error("reserved bit");

  property p_wr;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n && {dev_cmd.bg[0], dev_cmd.ba} == 3'h0 |->
        {dev_cmd.addr[13], dev_cmd.addr[11:9]} <= 4'h9;
  endproperty
  a_wr: assert property (p_wr) else $error("recovery code");

  property p_burst;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n && {dev_cmd.bg[0], dev_cmd.ba} == 3'h0 |->
        dev_cmd.addr[1:0] != 2'h3;
  endproperty
  a_burst: assert property (p_burst) else $error("burst code");

  property p_quiet;
    @(posedge clk) disable iff (!resetn)
      state_q != msc_pkg::MSC_WAIT_MRD |-> dev_cmd.cs_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray command");

  property p_act;
    @(posedge clk) disable iff (!resetn)
      !dev_cmd.cs_n |-> dev_cmd.act_n;
  endproperty
  a_act: assert property (p_act) else $error("activate low");

  property p_done;
    @(posedge clk) disable iff (!resetn)
      $rose(done_q) |-> state_q == msc_pkg::MSC_IDLE && !cmd_block;
  endproperty
  a_done: assert property (p_done) else $error("early done");

  property p_term;
    @(posedge clk) disable iff (!resetn)
      cmd_block |-> !termination_input;
  endproperty
  a_term: assert property (p_term) else $error("term high");
endmodule

// [msc_map.svh]
// Purpose: Constants for the mode-set controller and its register bank
// Assumes: 10 MHz clock, APB register offsets as below
// Notes: Mode register zero bit positions follow the pin mapping
// How it works
// - Keep mode-set-to-mode-set delay between two mode-set commands.
// - Wait mode-set-to-command delay before other non-deselect commands.
// - Special-timing updates skip that delay; software times them.
// - Mode-set only when idle: banks precharged, clock enable high.
// - Nominal termination on: termination input low until delay ends.
// - Nominal termination off both sides: termination input may be free.
// - Longer updates follow their own procedure before the next command.
// - Row, column and write strobes all low during a mode-set command.
// - Reserved bits 21 and 17 of register zero are written zero.
// - Needs beyond 28/14 clocks are programmed as 28/14.
// - No footnoted recovery or latency codes with quarter-rate gear-down.
// - Bit 7 stays zero; one enters factory test mode.
// - Every field of the addressed register is written each time.
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH
`define MSC_OFF_CTRL 12'h000
`define MSC_OFF_DATA 12'h004
`define MSC_OFF_STAT 12'h008
`define MSC_OFF_TIME 12'h00C
`define MSC_CTRL_GO 0
`define MSC_CTRL_RTT 1
`define MSC_CTRL_GEAR 2
`define MSC_CTRL_SPECIAL 3
`define MSC_STAT_BUSY 0
`define MSC_STAT_ERR 1
`define MSC_STAT_DONE 2
`define MSC_STAT_IDLE 3
`define MSC_MRD_CYC 8'h08
`define MSC_MOD_CYC 8'h18
`define MSC_SEL_LO 18
`define MSC_BIT_RFU_HI 21
`define MSC_BIT_RFU_LO 17
`define MSC_BIT_TM 7
`endif

// [msc_pkg.sv]
// Purpose: Types for the mode-set controller
// Assumes: Constants come from msc_map.svh
// Notes: None
package msc_pkg;
  typedef enum logic [1:0] {MSC_IDLE, MSC_ISSUE, MSC_WAIT_MRD, MSC_WAIT_MOD}
    msc_state_t;
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } msc_cmd_t;
endpackage

// [msc_dev.sv]
// Purpose: Device-side model that captures mode-set commands
// Assumes: Commands are sampled on the rising clock edge
// Notes: Misuse of the pins is counted in viol_q
`timescale 1ns/1ns
`include "msc_map.svh"
module msc_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins from the controller
  input wire msc_pkg::msc_cmd_t dev_cmd,
  input wire logic termination_input,
  // Observed state
  output logic [21:0] last_q,
  output logic [21:0] mr0_q,
  output int cnt_q,
  output int since_q,
  output int viol_q
);
  always @(posedge clk) begin
    logic [21:0] v;
    int e;
    v = {dev_cmd.bg, dev_cmd.ba, dev_cmd.addr[17], 3'b000,
         dev_cmd.addr[13:0]};
    e = viol_q;
    if (termination_input !== 1'b0) e++;
    if (dev_cmd.cs_n === 1'b0) begin
      if ({dev_cmd.act_n, dev_cmd.ras_n, dev_cmd.cas_n, dev_cmd.we_n}
          !== 4'b1000) e++;
      if (since_q < int'(`MSC_MRD_CYC) - 1) e++;
      if (v[20:18] === 3'b111) e++;
      if (v[20:18] === 3'b000) begin
        if (v[21] | v[17] | v[7]) e++;
        mr0_q <= v;
      end
      last_q <= v;
      cnt_q <= cnt_q + 1;
      since_q <= 0;
    end else if (since_q < 1000) begin
      since_q <= since_q + 1;
    end
    viol_q <= e;
    if (!resetn) begin
      cnt_q <= 0;
      since_q <= 1000;
      viol_q <= 0;
      mr0_q <= '0;
      last_q <= '0;
    end
  end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the mode-set controller
// Assumes: Zero-wait APB slave, device model on the command pins
// Notes: Random legal register values from a fixed seed
`timescale 1ns/1ns
`include "msc_map.svh"
module testbench;
  logic clk, resetn, psel, penable, pwrite, dev_idle, cke_high;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic pready, pslverr, cmd_block, term, blk_p;
  msc_pkg::msc_cmd_t dev_cmd;
  logic [21:0] last_v, mr0_v, v;
  logic [26:0] tab [10];
  int cnt, since, viol, blk_len, num_errors, n_tests, ec;
  msc_ctrl uut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_idle(dev_idle), .cke_high(cke_high), .cmd_block(cmd_block),
    .dev_cmd(dev_cmd), .termination_input(term));
  msc_dev dev (.clk(clk), .resetn(resetn), .dev_cmd(dev_cmd),
    .termination_input(term), .last_q(last_v), .mr0_q(mr0_v),
    .cnt_q(cnt), .since_q(since), .viol_q(viol));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input logic [21:0] val, input logic [3:0] ctl);
    int n;
    apb(1'b1, `MSC_OFF_DATA, {10'h000, val});
    apb(1'b1, `MSC_OFF_CTRL, {28'h000_0000, ctl | 4'h1});
    n = 0;
    do begin
      apb(1'b0, `MSC_OFF_STAT, '0);
      n++;
    end while (q[2:1] == 2'b00 && n < 100);
    st = q;
    apb(1'b1, `MSC_OFF_STAT, 32'h0000_0006);
  endtask
  function automatic logic [21:0] legal(input logic [31:0] r,
                                        input logic other);
    logic [21:0] x;
    logic [3:0] wr;
    logic [4:0] cl;
    wr = 4'(r[3:0] % 10);
    cl = 5'(r[8:4] % 24);
    x = {8'h00, wr[3], cl[4], wr[2:0], r[9], 1'b0, cl[3:1], r[10],
         cl[0], 2'(r[12:11] % 3)};
    if (other) x = {r[21], 3'(r[20:18] % 6 + 1), r[17], 3'b000, r[13:0]};
    return x;
  endfunction
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    blk_p <= cmd_block;
    if (blk_p === 1'b1 && cmd_block === 1'b0) blk_len <= since;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 60000);
    num_errors++;
    print_verdict;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    {dev_idle, cke_high, num_errors, n_tests} = {2'b11, 64'h0};
    tab = '{27'h41C_0000, 27'h420_0000, 27'h402_0000, 27'h400_0080,
      27'h400_2400, 27'h400_0003, 27'h400_1040, 27'h500_0200, 27'h100_2204,
      27'h500_0260};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    void'($urandom(63));
    apb(1'b0, `MSC_OFF_TIME, '0);
    chk(q, 32'h0000_1808);
    apb(1'b0, `MSC_OFF_STAT, '0);
    chk(q, 32'h0000_0008);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, '0);
    chk(q, 32'h0000_0000);
    chk({31'h0, pslverr}, 32'h0000_0000);
    apb(1'b1, `MSC_OFF_CTRL, 32'h0000_000E);
    apb(1'b0, `MSC_OFF_CTRL, '0);
    chk(q, 32'h0000_000E);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      v = legal($urandom, i % 3 == 2);
      ec = cnt;
      run(v, (i % 4 == 1) ? 4'h8 : 4'h0);
      chk({29'h0, st[2:0]}, 32'h0000_0004);
      chk(last_v, v);
      chk(cnt, ec + 1);
      if (v[20:18] == 3'b000) chk(mr0_v, v);
      chk(blk_len + 1 >= ((i % 4 == 1) ? 8 : 24), 1);
    end
    $display("test random done");
    for (int i = 0; i < 10; i++) begin
      ec = cnt;
      run(tab[i][21:0], tab[i][25:22]);
      chk({31'h0, st[1]}, {31'h0, tab[i][26]});
      chk(cnt, ec + (tab[i][26] ? 0 : 1));
    end
    for (int i = 0; i < 2; i++) begin
      dev_idle <= i[0];
      cke_high <= ~i[0];
      ec = cnt;
      run(22'h00_0204, 4'h0);
      chk({31'h0, st[1]}, 32'h0000_0001);
      chk(cnt, ec);
    end
    chk(viol, 0);
    $display("test refusals done");
    print_verdict;
  end
endmodule
